//--- rtl/cmp_skip_pkg.sv
package cmp_skip_pkg;
   // ----------------------------------------
   // Opcode fields
   // ----------------------------------------
   localparam logic [5:0] COMPLEMENT_REGISTER_OP = 6'h07;  // 0001 11
   localparam logic [6:0] COMPARE_SKIP_EQUAL_OP = 7'h31;   // 0110 001
   localparam logic [6:0] COMPARE_SKIP_GREATER_OP = 7'h32; // 0110 010
   localparam logic [6:0] COMPARE_SKIP_LESS_OP = 7'h30;    // 0110 000
   localparam int DEST_BIT = 9;
   localparam int ACCESS_BIT = 8;
   localparam logic [7:0] INDEXED_MAX = 8'h5F;
   localparam logic [7:0] ACCESS_SPLIT = 8'h80;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
   localparam logic [7:0] WORKING_REGISTER_ALIAS_RESET = 8'h00;
   localparam logic [1:0] SKIP_ONE_WORD = 2'h1;
   localparam logic [1:0] SKIP_TWO_WORD = 2'h2;

   // ----------------------------------------
   // Phases and carriers
   // ----------------------------------------
   typedef enum logic [1:0] {
      PH_DECODE = 2'b00,
      PH_READ = 2'b01,
      PH_PROCESS = 2'b10,
      PH_WRITE = 2'b11
   } phase_e;

   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] data;
      logic we;
      logic re;
   } mem_req_s;

   typedef struct packed {
      logic neg;
      logic zero;
      logic upd;
   } flag_upd_s;
endpackage

//--- rtl/cmp_skip_exec.sv
`timescale 1ns/10ps
// Summary of operation
// - The complement op yields the inverted file register and updates only the negative and zero flags.
// - Destination bit 0 writes the working register, bit 1 writes back to the file register.
// - Access bit 0 selects the access bank, bit 1 forms the address from the bank select register.
// - Indexed literal offset applies when access bit is 0, extended set is on, and file field is at most 5Fh.
// - Compare-equal skips when the file register equals the working register, flags untouched.
// - Compare-greater skips when the file register exceeds the working register unsigned, flags untouched.
// - Compare-less skips when the file register is below the working register unsigned, flags untouched.
// - A skip runs one no-operation cycle, or two if the skipped instruction is two words long.
module cmp_skip_exec
   import cmp_skip_pkg::*;
(
   input wire logic mclk_i,               // Instruction clock
   input wire logic srst_i,               // Synchronous reset
   input wire logic [15:0] instr_i,       // Fetched instruction word
   input wire logic next_two_word_i,      // Next fetched is two-word
   input wire logic ext_set_en_i,         // Extended instruction set on
   input wire logic [3:0] bank_select_register_i, // Bank select
   input wire logic [11:0] index_base_i,  // Literal offset base pointer
   input wire logic [7:0] rd_data_i,      // File register read data
   output mem_req_s mem_o,                // Data memory request
   output logic [7:0] working_register_alias_o, // Working register
   output flag_upd_s flag_o,              // Flag update
   output logic skip_o,                   // Skip cycle in progress
   output logic [1:0] phase_o             // Current phase
);
   phase_e phase_reg;
   logic [15:0] ir_reg;
   logic [7:0] opnd_reg;
   logic [7:0] working_register_alias_reg;
   logic [1:0] skip_cnt_reg;
   logic skip_take_reg;
   mem_req_s mem_reg;
   flag_upd_s flag_reg;
   logic [11:0] addr_next;
   logic is_comp, is_eq, is_gt, is_lt, skipping;
   logic [7:0] ffield;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   assign ffield = ir_reg[7:0];
   assign skipping = (skip_cnt_reg != 2'h0);
   assign is_comp = !skipping && (ir_reg[15:10] == COMPLEMENT_REGISTER_OP);
   assign is_eq = !skipping && (ir_reg[15:9] == COMPARE_SKIP_EQUAL_OP);
   assign is_gt = !skipping && (ir_reg[15:9] == COMPARE_SKIP_GREATER_OP);
   assign is_lt = !skipping && (ir_reg[15:9] == COMPARE_SKIP_LESS_OP);

   // Address formation
   always_comb begin
      if (ir_reg[ACCESS_BIT]) begin
         addr_next = {bank_select_register_i, ffield};
      end else if (ext_set_en_i && ffield <= INDEXED_MAX) begin
         addr_next = index_base_i + {4'h0, ffield};
      end else if (ffield < ACCESS_SPLIT) begin
         addr_next = {4'h0, ffield};
      end else begin
         addr_next = {ACCESS_HIGH_BANK, ffield};
      end
   end

   // ----------------------------------------
   // Phase sequencing
   // ----------------------------------------
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         phase_reg <= PH_DECODE;
      end else begin
         case (phase_reg)
            PH_DECODE: phase_reg <= PH_READ;
            PH_READ: phase_reg <= PH_PROCESS;
            PH_PROCESS: phase_reg <= PH_WRITE;
            PH_WRITE: phase_reg <= PH_DECODE;
            default: phase_reg <= PH_DECODE;
         endcase
      end
   end

   // Instruction latch in write phase, ahead of decode
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         ir_reg <= 16'h0000;
      end else if (phase_reg == PH_WRITE) begin
         ir_reg <= instr_i;
      end
   end

   // Skip cycle counter
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         skip_cnt_reg <= 2'h0;
      end else if (phase_reg == PH_WRITE) begin
         if (skip_take_reg) begin
            skip_cnt_reg <= next_two_word_i ? SKIP_TWO_WORD : SKIP_ONE_WORD;
         end else if (skipping) begin
            skip_cnt_reg <= skip_cnt_reg - 2'h1;
         end
      end
   end

   // Compare result captured in process phase
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         skip_take_reg <= 1'b0;
      end else if (phase_reg == PH_PROCESS) begin
         skip_take_reg <= (is_eq && rd_data_i == working_register_alias_reg) || (is_gt && rd_data_i > working_register_alias_reg)
            || (is_lt && rd_data_i < working_register_alias_reg);
      end else if (phase_reg == PH_WRITE) begin
         skip_take_reg <= 1'b0;
      end
   end

   // Skip flag output
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         skip_o <= 1'b0;
      end else begin
         // At the cycle boundary, look ahead to whether the next cycle is idle
         if (phase_reg == PH_WRITE) begin
            skip_o <= skip_take_reg || (skip_cnt_reg > SKIP_ONE_WORD);
         end else begin
            skip_o <= skipping;
         end
      end
   end

   // ----------------------------------------
   // Data path
   // ----------------------------------------
   // Operand captured in process phase
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         opnd_reg <= 8'h00;
      end else if (phase_reg == PH_PROCESS) begin
         opnd_reg <= rd_data_i;
      end
   end

   // Memory request per phase
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         mem_reg <= '0;
      end else begin
         mem_reg.re <= (phase_reg == PH_DECODE) && (is_comp || is_eq || is_gt || is_lt);
         mem_reg.we <= (phase_reg == PH_PROCESS) && is_comp && ir_reg[DEST_BIT];
         if (phase_reg == PH_DECODE) begin
            mem_reg.addr <= addr_next;
         end
         if (phase_reg == PH_PROCESS) begin
            mem_reg.data <= ~rd_data_i;
         end
      end
   end

   // Working register and flags
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         working_register_alias_reg <= WORKING_REGISTER_ALIAS_RESET;
         flag_reg <= '0;
      end else begin
         flag_reg.upd <= 1'b0;
         if (phase_reg == PH_PROCESS && is_comp) begin
            flag_reg.neg <= ~rd_data_i[7];
            flag_reg.zero <= (rd_data_i == 8'hFF);
            flag_reg.upd <= 1'b1;
            if (!ir_reg[DEST_BIT]) begin
               working_register_alias_reg <= ~rd_data_i;
            end
         end
      end
   end

   assign mem_o = mem_reg;
   assign flag_o = flag_reg;
   assign working_register_alias_o = working_register_alias_reg;
   assign phase_o = phase_reg;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (srst_i);

   phase_order_a: assert property (phase_reg == PH_WRITE |=> phase_reg == PH_DECODE)
      else $error("phase did not wrap");
   comp_flags_a: assert property (flag_reg.upd |-> $past(is_comp))
      else $error("flags updated by non-complement");
   comp_dest_a: assert property (mem_reg.we |-> $past(is_comp) && $past(ir_reg[DEST_BIT]))
      else $error("write with wrong destination");
   comp_data_a: assert property (mem_reg.we |-> mem_reg.data == ~$past(rd_data_i))
      else $error("write data not inverted");
   working_register_alias_keep_a: assert property ($changed(working_register_alias_reg) |-> $past(is_comp) && !$past(ir_reg[DEST_BIT]))
      else $error("working register changed wrongly");
   bank_addr_a: assert property (phase_reg == PH_DECODE && ir_reg[ACCESS_BIT]
      |=> mem_reg.addr == {$past(bank_select_register_i), $past(ffield)})
      else $error("banked address wrong");
   indexed_a: assert property (phase_reg == PH_DECODE && !ir_reg[ACCESS_BIT] && ext_set_en_i
      && ffield <= INDEXED_MAX |=> mem_reg.addr == $past(index_base_i) + {4'h0, $past(ffield)})
      else $error("indexed address wrong");
   eq_skip_a: assert property (phase_reg == PH_PROCESS && is_eq && rd_data_i == working_register_alias_reg
      |=> ##1 skip_o)
      else $error("equal did not skip");
   gt_skip_a: assert property (phase_reg == PH_PROCESS && is_gt && rd_data_i > working_register_alias_reg
      |=> ##1 skip_o)
      else $error("greater did not skip");
   skip_result_a: assert property (phase_reg == PH_WRITE |-> skip_take_reg == ((is_eq && opnd_reg == working_register_alias_reg)
      || (is_gt && opnd_reg > working_register_alias_reg) || (is_lt && opnd_reg < working_register_alias_reg)))
      else $error("skip decision wrong");
   flag_hold_a: assert property (!$past(is_comp) |-> $stable(flag_reg.neg) && $stable(flag_reg.zero))
      else $error("flags changed by compare");
   lt_noskip_a: assert property (phase_reg == PH_PROCESS && is_lt && rd_data_i >= working_register_alias_reg
      |=> !skip_take_reg)
      else $error("less skipped wrongly");
   skip_idle_a: assert property (skipping |-> !mem_reg.we && !flag_reg.upd)
      else $error("skip cycle not idle");

   skip_cov_c: cover property (skip_take_reg && phase_reg == PH_WRITE);
   skip2_cov_c: cover property (skip_cnt_reg == SKIP_TWO_WORD);
   comp_w_cov_c: cover property (is_comp && !ir_reg[DEST_BIT] && phase_reg == PH_PROCESS);
   indexed_cov_c: cover property (phase_reg == PH_DECODE && !ir_reg[ACCESS_BIT] && ext_set_en_i);
   gt_cov_c: cover property (is_gt && phase_reg == PH_WRITE && skip_take_reg);
endmodule // cmp_skip_exec

//--- sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import cmp_skip_pkg::*;
   logic mclk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [15:0] instr_i = 16'h0000;
   logic next_two_word_i = 1'b0;
   logic ext_set_en_i = 1'b0;
   logic [3:0] bank_select_register_i = 4'h5;
   logic [11:0] index_base_i = 12'h300;
   logic [7:0] rd_data_i = 8'h00;
   mem_req_s mem_o;
   logic [7:0] working_register_alias_o;
   flag_upd_s flag_o;
   logic skip_o;
   logic [1:0] phase_o;
   int n_mismatch = 0;
   int checks_done = 0;

   cmp_skip_exec DUT (.mclk_i(mclk_i), .srst_i(srst_i), .instr_i(instr_i), .next_two_word_i(next_two_word_i),
      .ext_set_en_i(ext_set_en_i), .bank_select_register_i(bank_select_register_i),
      .index_base_i(index_base_i), .rd_data_i(rd_data_i), .mem_o(mem_o),
      .working_register_alias_o(working_register_alias_o), .flag_o(flag_o), .skip_o(skip_o), .phase_o(phase_o));

   // Free running clock
   always #25 mclk_i = ~mclk_i;

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_sim;
      if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // One instruction: feed it, follow its phases, count skip cycles
   task automatic exec(input logic [15:0] ins, input logic [7:0] rd, input logic two, input logic [11:0] ea,
                       input logic [7:0] ew, input logic cmpl, input int eskip);
      logic [7:0] res;
      int cnt;
      logic bad;
      res = ~rd;
      cnt = 0;
      bad = 1'b0;
      for (int i = 0; i < 8 && phase_o !== 2'h3; i++) begin
         @(posedge mclk_i);
         #1;
      end
      instr_i = ins;
      rd_data_i = rd;
      next_two_word_i = two;
      @(posedge mclk_i);
      #1;
      chk("phase", 16'(phase_o), 16'h0000);
      @(posedge mclk_i);
      #1;
      chk("read", 16'(mem_o.re), 16'h0001);
      chk("addr", 16'(mem_o.addr), 16'(ea));
      repeat (2) @(posedge mclk_i);
      #1;
      chk("write", 16'(mem_o.we), 16'(cmpl & ins[DEST_BIT]));
      if (mem_o.we === 1'b1) chk("wdata", 16'(mem_o.data), 16'(res));
      chk("upd", 16'(flag_o.upd), 16'(cmpl));
      if (cmpl) chk("nz", 16'({flag_o.neg, flag_o.zero}), 16'({res[7], res == 8'h00}));
      // Junk fetch during a skip must be discarded
      instr_i = (eskip > 0) ? 16'h1C10 : 16'h0000;
      repeat (9) begin
         @(posedge mclk_i);
         #1;
         instr_i = 16'h0000;
         if (skip_o === 1'b1) cnt++;
         bad = bad | (skip_o & (mem_o.re | mem_o.we));
      end
      chk("skip", 16'(cnt), 16'(eskip));
      chk("idle", 16'(bad), 16'h0000);
      chk("working_register_alias", 16'(working_register_alias_o), 16'(ew));
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic test_complement;
      exec(16'h1C13, 8'h13, 1'b0, 12'h013, 8'hEC, 1'b1, 0);
      exec(16'h1FA0, 8'hFF, 1'b0, 12'h5A0, 8'hEC, 1'b1, 0);
      exec(16'h1C85, 8'h01, 1'b0, 12'hF85, 8'hFE, 1'b1, 0);
   endtask

   task automatic test_indexed;
      ext_set_en_i = 1'b1;
      exec(16'h1C5F, 8'h80, 1'b0, 12'h35F, 8'h7F, 1'b1, 0);
   endtask

   task automatic test_equal;
      exec(16'h6260, 8'h7F, 1'b0, 12'h060, 8'h7F, 1'b0, 4);
      exec(16'h6360, 8'h7E, 1'b0, 12'h560, 8'h7F, 1'b0, 0);
   endtask

   task automatic test_greater;
      exec(16'h6410, 8'h80, 1'b1, 12'h310, 8'h7F, 1'b0, 8);
      exec(16'h6510, 8'h7F, 1'b0, 12'h510, 8'h7F, 1'b0, 0);
      exec(16'h6520, 8'hFF, 1'b0, 12'h520, 8'h7F, 1'b0, 4);
   endtask

   task automatic test_less;
      exec(16'h6010, 8'h7E, 1'b1, 12'h310, 8'h7F, 1'b0, 8);
      exec(16'h6110, 8'h7F, 1'b0, 12'h510, 8'h7F, 1'b0, 0);
      exec(16'h61FF, 8'h00, 1'b0, 12'h5FF, 8'h7F, 1'b0, 4);
   endtask

   // Main sequence
   initial begin
      repeat (12) @(posedge mclk_i);
      #1;
      chk("rst", 16'({working_register_alias_o, skip_o, phase_o, mem_o.we, mem_o.re}), 16'h0000);
      srst_i = 1'b0;
      test_complement();
      test_indexed();
      test_equal();
      test_greater();
      test_less();
      end_sim();
   end

   // Watchdog against a hang
   initial begin
      #50000;
      n_mismatch++;
      end_sim();
   end
endmodule // tb_top
